// ===== hdl/ext_bus_latch_pkg.sv
// constants for the external bus latch timing and clock divider block
package ext_bus_latch_pkg;
   // ============
   // register word offsets (byte addresses, one word each except the two eight-word bases)
   localparam logic [7:0] LATCH_TIMING_BASE = 8'h00; // eight words
   localparam logic [7:0] CLOCK_DIVIDER_OFS = 8'h20;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h24;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h28;
   localparam logic [7:0] BUS_CTRL_OFS = 8'h2c;
   localparam logic [7:0] AREA_BASE_OFS = 8'h40; // eight words
   localparam int NUM_AREAS = 8;
   localparam int AREA_IDX_W = 3;
   // ============
   // latch timing fields
   localparam int HOLD_LSB = 0;
   localparam int SETUP_LSB = 4;
   localparam int WIDTH_LSB = 8;
   localparam int FIELD_W = 4;
   localparam logic [11:0] LATCH_TIMING_RST = 12'h45f;
   // ============
   // clock divider fields
   localparam int RATIO_LSB = 0;
   localparam int DIV_EN_BIT = 4;
   localparam logic [4:0] CLOCK_DIVIDER_RST = 5'h01;
   // ============
   // area fields: base at 7:0, mask at 22:16
   localparam int AREA_BASE_LSB = 0;
   localparam int AREA_MASK_LSB = 16;
   localparam int AREA_MASK_W = 7;
   localparam logic [6:0] AREA_MASK_RST = 7'h0f;
   // ============
   // bus control bits: 0 multiplexed mode
   localparam int MUX_MODE_BIT = 0;
   // ============
   // interrupt status bits
   localparam int IRQ_UNMAPPED = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_W = 2;
   // ============
   // response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_ERROR = 2'h1;
   // ============
   // fixed access lengths, in cycles
   localparam logic [4:0] DATA_CYCLES = 5'h04;
   localparam logic [4:0] IDLE_CYCLES = 5'h01;
endpackage

// ===== hdl/clock_divider_gen.sv
// external bus clock divider
`timescale 1ns/100ps
module clock_divider_gen
(
   input wire logic ref_clk_i, // system clock
   input wire logic nrst_i, // async reset, low
   input wire logic divider_enable_i, // 0 gives undivided
   input wire logic [3:0] division_ratio_i, // divide by this plus one
   output logic ext_clk_o, // divided clock level
   output logic ext_clk_rise_o // one cycle at the start of each divided period
);
   // ============
   // counter
   logic [3:0] cnt_r; // phase counter
   logic [3:0] ratio; // effective ratio
   logic [4:0] half; // low phase length

   // undivided unless enabled
   assign ratio = divider_enable_i ? division_ratio_i : 4'h0;

   // low for the first half of the period
   assign half = ({1'b0, ratio} + 5'h01) >> 1;

   // period of ratio plus one cycles
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_r <= 4'h0;
      else if (cnt_r >= ratio)
         cnt_r <= 4'h0;
      else
         cnt_r <= cnt_r + 4'h1;
   end

   // output level, undivided gives a steady high stand-in
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ext_clk_o <= 1'b0;
      else if (ratio == 4'h0)
         ext_clk_o <= 1'b1;
      else
         ext_clk_o <= ({1'b0, cnt_r} < half) ? 1'b0 : 1'b1;
   end

   // marks the start of each divided period
   assign ext_clk_rise_o = (cnt_r == 4'h0);
endmodule // clock_divider_gen

// ===== hdl/ext_bus_latch.sv
// address latch timing, area decode and clock divider of the external bus
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - latch strobe high for width plus one
// - strobe held low setup cycles after start
// - address driven hold field plus one cycles
// - latch timing only in multiplexed mode
// - minimal variant drops latch and divider registers
// - divider disabled means undivided clock
// - divide clock by ratio plus one
// - unmapped window access returns error response
// - latch timing and divider rewrites during a dma access apply after access and idle
// - area hit on masked address compare
module ext_bus_latch
#(
   parameter bit MINIMAL_VARIANT = 1'b0 // minimal product variant
)
(
   input wire logic ref_clk_i, // system clock, 250 MHz
   input wire logic nrst_i, // async reset, low
   // register port
   input wire logic [7:0] reg_addr_i, // byte address
   input wire logic [31:0] reg_wdata_i, // write data
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   output logic [31:0] reg_rdata_o, // read data, cycle after strobe
   // internal bus access request
   input wire logic acc_req_i, // start of an access, one cycle
   input wire logic [27:0] acc_addr_i, // address inside the window
   input wire logic acc_dma_i, // access issued by dma
   output logic acc_busy_o, // access in progress
   output logic acc_done_o, // access finished, one cycle
   output logic [1:0] acc_resp_o, // response, with done
   // external side
   output logic [ext_bus_latch_pkg::AREA_IDX_W-1:0] area_sel_o, // area
   output logic chip_sel_o, // chip select active
   output logic address_latch_strobe_o, // latch strobe
   output logic addr_on_data_o, // address on shared lines
   output logic ext_clk_o, // divided bus clock
   output logic irq_o // level interrupt
);
   import ext_bus_latch_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_DATA, ST_GAP,
                             ST_ERR} acc_state_t;

   // ============
   // declarations
   logic [11:0] latch_timing_r [NUM_AREAS]; // programmed timings
   logic [11:0] latch_pend_r [NUM_AREAS]; // pending timings
   logic [NUM_AREAS-1:0] latch_dirty_r; // pending write waits
   logic [4:0] clk_div_r; // active divider setting
   logic [4:0] clk_div_pend_r; // pending divider setting
   logic clk_div_dirty_r; // divider write waits
   logic [7:0] area_base_r [NUM_AREAS]; // area base fields
   logic [6:0] area_mask_r [NUM_AREAS]; // area mask fields
   logic [NUM_AREAS-1:0] area_en_r; // area configured
   logic mux_mode_r; // multiplexed bus mode
   logic [IRQ_W-1:0] irq_stat_r; // sticky events
   logic [IRQ_W-1:0] irq_mask_r; // event enables
   logic [IRQ_W-1:0] irq_set; // events this cycle
   acc_state_t state_r; // access state
   logic [4:0] cnt_r; // cycle in state
   logic [AREA_IDX_W-1:0] area_r; // latched area
   logic dma_r; // access from dma
   logic [NUM_AREAS-1:0] hit; // per area match
   logic any_hit; // any area matches
   logic [AREA_IDX_W-1:0] hit_idx; // lowest match
   logic [11:0] cur_t; // timing in use
   logic [4:0] latch_len; // latch phase length
   logic defer; // hold back register updates
   logic [31:0] rdata_nxt; // read mux

   // ============
   // helpers
   // masked compare of address bits against an area
   function automatic logic area_match(input logic [7:0] a,
                                       input logic [7:0] base,
                                       input logic [6:0] msk);
      logic [7:0] m;
      m = {1'b0, msk};
      return (a & ~m) == (base & ~m);
   endfunction

   // is the address a register word
   function automatic logic is_ofs(input logic [7:0] a,
                                   input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ============
   // area decode
   generate
      for (genvar g = 0; g < NUM_AREAS; g++)
      begin : g_hit
         assign hit[g] = area_en_r[g] &&
                         area_match(acc_addr_i[27:20], area_base_r[g],
                                    area_mask_r[g]);
      end
   endgenerate

   // lowest matching area wins
   always_comb
   begin
      hit_idx = '0;
      for (int i = NUM_AREAS - 1; i >= 0; i--)
      begin
         if (hit[i])
            hit_idx = AREA_IDX_W'(i);
      end
   end
   assign any_hit = |hit;

   // ============
   // access sequencer
   assign cur_t = latch_timing_r[area_r];
   // setup plus width plus one, or hold plus one when that is longer
   always_comb
   begin
      latch_len = {1'b0, cur_t[SETUP_LSB +: FIELD_W]} +
                  {1'b0, cur_t[WIDTH_LSB +: FIELD_W]} + 5'h01;
      if ({1'b0, cur_t[HOLD_LSB +: FIELD_W]} + 5'h01 > latch_len)
         latch_len = {1'b0, cur_t[HOLD_LSB +: FIELD_W]} + 5'h01;
   end

   // state and cycle count
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 5'h00;
         area_r <= '0;
         dma_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_r + 5'h01;
         case (state_r)
            ST_IDLE:
            begin
               cnt_r <= 5'h00;
               if (acc_req_i)
               begin
                  dma_r <= acc_dma_i;
                  area_r <= hit_idx;
                  if (!any_hit)
                     state_r <= ST_ERR;
                  else if (mux_mode_r && !MINIMAL_VARIANT)
                     state_r <= ST_LATCH;
                  else
                     state_r <= ST_DATA;
               end
            end
            ST_LATCH:
               if (cnt_r == latch_len - 5'h01)
               begin
                  state_r <= ST_DATA;
                  cnt_r <= 5'h00;
               end
            ST_DATA:
               if (cnt_r == DATA_CYCLES - 5'h01)
               begin
                  state_r <= ST_GAP;
                  cnt_r <= 5'h00;
               end
            ST_GAP:
               if (cnt_r == IDLE_CYCLES - 5'h01)
                  state_r <= ST_IDLE;
            ST_ERR:
               state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // strobe, address phase and outputs
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         address_latch_strobe_o <= 1'b0;
         addr_on_data_o <= 1'b0;
         chip_sel_o <= 1'b0;
         area_sel_o <= '0;
      end
      else
      begin
         address_latch_strobe_o <= (state_r == ST_LATCH) &&
            (cnt_r >= {1'b0, cur_t[SETUP_LSB +: FIELD_W]}) &&
            (cnt_r < {1'b0, cur_t[SETUP_LSB +: FIELD_W]} +
                     {1'b0, cur_t[WIDTH_LSB +: FIELD_W]} +
                     5'h01);
         addr_on_data_o <= (state_r == ST_LATCH) &&
            (cnt_r <= {1'b0, cur_t[HOLD_LSB +: FIELD_W]});
         chip_sel_o <= (state_r == ST_LATCH) || (state_r == ST_DATA);
         area_sel_o <= area_r;
      end
   end

   // done pulse and response
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         acc_done_o <= 1'b0;
         acc_resp_o <= RESP_OKAY;
      end
      else
      begin
         acc_done_o <= (state_r == ST_ERR) ||
                       (state_r == ST_GAP && cnt_r == IDLE_CYCLES - 5'h01);
         acc_resp_o <= (state_r == ST_ERR) ? RESP_ERROR : RESP_OKAY;
      end
   end
   assign acc_busy_o = (state_r != ST_IDLE);

   // dma access holds updates until after its idle cycle
   assign defer = acc_busy_o && dma_r;

   // ============
   // register writes
   // latch timing words, deferred during dma access
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < NUM_AREAS; i++)
         begin
            latch_timing_r[i] <= LATCH_TIMING_RST;
            latch_pend_r[i] <= LATCH_TIMING_RST;
         end
         latch_dirty_r <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_AREAS; i++)
         begin
            if (reg_wr_i && !MINIMAL_VARIANT &&
                is_ofs(reg_addr_i, LATCH_TIMING_BASE + 8'(i * 4)))
            begin
               if (defer)
               begin
                  latch_pend_r[i] <= reg_wdata_i[11:0];
                  latch_dirty_r[i] <= 1'b1;
               end
               else
                  latch_timing_r[i] <= reg_wdata_i[11:0];
            end
            else if (!defer && latch_dirty_r[i])
            begin
               latch_timing_r[i] <= latch_pend_r[i];
               latch_dirty_r[i] <= 1'b0;
            end
         end
      end
   end

   // divider word, deferred during dma access
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         clk_div_r <= CLOCK_DIVIDER_RST;
         clk_div_pend_r <= CLOCK_DIVIDER_RST;
         clk_div_dirty_r <= 1'b0;
      end
      else if (reg_wr_i && !MINIMAL_VARIANT &&
               is_ofs(reg_addr_i, CLOCK_DIVIDER_OFS))
      begin
         if (defer)
         begin
            clk_div_pend_r <= reg_wdata_i[4:0];
            clk_div_dirty_r <= 1'b1;
         end
         else
            clk_div_r <= reg_wdata_i[4:0];
      end
      else if (!defer && clk_div_dirty_r)
      begin
         clk_div_r <= clk_div_pend_r;
         clk_div_dirty_r <= 1'b0;
      end
   end

   // area words, mode and mask
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < NUM_AREAS; i++)
         begin
            area_base_r[i] <= 8'(i * 16);
            area_mask_r[i] <= AREA_MASK_RST;
         end
         area_en_r <= '1;
         mux_mode_r <= 1'b0;
         irq_mask_r <= '0;
      end
      else if (reg_wr_i)
      begin
         for (int i = 0; i < NUM_AREAS; i++)
         begin
            if (is_ofs(reg_addr_i, AREA_BASE_OFS + 8'(i * 4)))
            begin
               area_base_r[i] <= reg_wdata_i[AREA_BASE_LSB +: 8];
               area_mask_r[i] <= reg_wdata_i[AREA_MASK_LSB +: AREA_MASK_W];
               area_en_r[i] <= reg_wdata_i[31];
            end
         end
         if (is_ofs(reg_addr_i, BUS_CTRL_OFS))
            mux_mode_r <= reg_wdata_i[MUX_MODE_BIT] && !MINIMAL_VARIANT;
         if (is_ofs(reg_addr_i, IRQ_MASK_OFS))
            irq_mask_r <= reg_wdata_i[IRQ_W-1:0];
      end
   end

   // ============
   // interrupts: set wins over write-one clear
   assign irq_set[IRQ_UNMAPPED] = (state_r == ST_ERR);
   assign irq_set[IRQ_DONE] = acc_done_o;
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_stat_r <= '0;
      else if (reg_wr_i && is_ofs(reg_addr_i, IRQ_STATUS_OFS))
         irq_stat_r <= (irq_stat_r & ~reg_wdata_i[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_r <= irq_stat_r | irq_set;
   end
   assign irq_o = |(irq_stat_r & irq_mask_r);

   // ============
   // read mux, unmapped reads zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      for (int i = 0; i < NUM_AREAS; i++)
      begin
         if (!MINIMAL_VARIANT &&
             is_ofs(reg_addr_i, LATCH_TIMING_BASE + 8'(i * 4)))
            rdata_nxt = {20'h00000, latch_timing_r[i]};
         if (is_ofs(reg_addr_i, AREA_BASE_OFS + 8'(i * 4)))
            rdata_nxt = {area_en_r[i], 8'h00, area_mask_r[i], 8'h00,
                         area_base_r[i]};
      end
      if (!MINIMAL_VARIANT && is_ofs(reg_addr_i, CLOCK_DIVIDER_OFS))
         rdata_nxt = {27'h0000000, clk_div_r};
      if (is_ofs(reg_addr_i, IRQ_STATUS_OFS))
         rdata_nxt = {30'h00000000, irq_stat_r};
      if (is_ofs(reg_addr_i, IRQ_MASK_OFS))
         rdata_nxt = {30'h00000000, irq_mask_r};
      if (is_ofs(reg_addr_i, BUS_CTRL_OFS))
         rdata_nxt = {29'h00000000, dma_r, acc_busy_o, mux_mode_r};
   end

   // read data register
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_nxt;
      else
         reg_rdata_o <= 32'h0000_0000;
   end

   // ============
   // bus clock divider
   clock_divider_gen u_div
   (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .divider_enable_i(clk_div_r[DIV_EN_BIT] && !MINIMAL_VARIANT),
      .division_ratio_i(clk_div_r[RATIO_LSB +: FIELD_W]),
      .ext_clk_o(ext_clk_o),
      .ext_clk_rise_o()
   );
endmodule // ext_bus_latch

// ===== dv/ext_bus_latch_props.sv
// port assertions for the external bus latch timing block
`timescale 1ns/100ps
module ext_bus_latch_props
(
   input wire logic ref_clk_i, // system clock
   input wire logic nrst_i, // async reset, low
   input wire logic acc_req_i, // access start
   input wire logic acc_busy_o, // access in progress
   input wire logic acc_done_o, // access end pulse
   input wire logic [1:0] acc_resp_o, // response code
   input wire logic chip_sel_o, // chip select
   input wire logic address_latch_strobe_o, // latch strobe
   input wire logic addr_on_data_o, // address phase
   input wire logic ext_clk_o // divided bus clock
);
   import ext_bus_latch_pkg::*;
   // ============
   // run counters
   logic [4:0] strobe_run_r; // strobe high cycles in a row
   logic [4:0] addr_run_r; // address phase cycles in a row
   // count consecutive high cycles of strobe and address phase
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         strobe_run_r <= 5'h00;
         addr_run_r <= 5'h00;
      end
      else
      begin
         strobe_run_r <= address_latch_strobe_o ? strobe_run_r + 5'h01 : 5'h00;
         addr_run_r <= addr_on_data_o ? addr_run_r + 5'h01 : 5'h00;
      end
   end
   // ============
   // properties
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_strobe_cs;
      address_latch_strobe_o |-> chip_sel_o;
   endproperty
   a_strobe_cs: assert property (p_strobe_cs)
      else $error("strobe off cs");
   property p_strobe_len;
      strobe_run_r <= 5'h10;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe too long");
   property p_addr_cs;
      addr_on_data_o |-> chip_sel_o;
   endproperty
   a_addr_cs: assert property (p_addr_cs)
      else $error("address off cs");
   property p_addr_len;
      addr_run_r <= 5'h10;
   endproperty
   a_addr_len: assert property (p_addr_len)
      else $error("address too long");
   property p_addr_start;
      $rose(addr_on_data_o) |-> $rose(chip_sel_o);
   endproperty
   a_addr_start: assert property (p_addr_start)
      else $error("address late");
   property p_err_done;
      acc_resp_o == RESP_ERROR |-> acc_done_o;
   endproperty
   a_err_done: assert property (p_err_done)
      else $error("error no done");
   property p_err_no_cs;
      acc_done_o && acc_resp_o == RESP_ERROR |->
         !chip_sel_o && !$past(chip_sel_o);
   endproperty
   a_err_no_cs: assert property (p_err_no_cs)
      else $error("error selected");
   property p_err_delay;
      acc_done_o && acc_resp_o == RESP_ERROR |-> $past(acc_req_i, 2);
   endproperty
   a_err_delay: assert property (p_err_delay)
      else $error("error timing");
   property p_done_pulse;
      acc_done_o |=> !acc_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done too long");
   // main scenarios reached
   c_strobe: cover property ($rose(address_latch_strobe_o));
   c_err: cover property (acc_done_o && acc_resp_o == RESP_ERROR);
   c_clk: cover property ($rose(ext_clk_o));
endmodule // ext_bus_latch_props
bind ext_bus_latch ext_bus_latch_props u_props (.ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i), .acc_req_i(acc_req_i), .acc_busy_o(acc_busy_o),
   .acc_done_o(acc_done_o), .acc_resp_o(acc_resp_o),
   .chip_sel_o(chip_sel_o), .address_latch_strobe_o(address_latch_strobe_o),
   .addr_on_data_o(addr_on_data_o), .ext_clk_o(ext_clk_o));

// ===== dv/mem_partner_model.sv
// external memory model that measures the latch phase of each access
`timescale 1ns/100ps
module mem_partner_model
(
   input wire logic ref_clk_i, // system clock
   input wire logic nrst_i, // async reset, low
   input wire logic chip_sel_i, // chip select from the block
   input wire logic latch_strobe_i, // address latch strobe
   input wire logic addr_phase_i, // address on shared lines
   input wire logic [ext_bus_latch_pkg::AREA_IDX_W-1:0] area_sel_i, // area
   output logic [4:0] strobe_cnt_o, // strobe cycles of last access
   output logic [4:0] setup_cnt_o, // cycles before strobe
   output logic [4:0] addr_cnt_o, // address cycles of last access
   output logic [ext_bus_latch_pkg::AREA_IDX_W-1:0] area_o // area latched
);
   import ext_bus_latch_pkg::*;
   logic cs_r; // chip select one cycle ago
   logic seen_r; // strobe already seen in this access
   // measure each selection; counters restart on chip select rise
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cs_r <= 1'b0;
         seen_r <= 1'b0;
         strobe_cnt_o <= 5'h00;
         setup_cnt_o <= 5'h00;
         addr_cnt_o <= 5'h00;
         area_o <= '0;
      end
      else
      begin
         cs_r <= chip_sel_i;
         if (chip_sel_i && !cs_r)
         begin
            seen_r <= latch_strobe_i;
            strobe_cnt_o <= 5'(latch_strobe_i);
            setup_cnt_o <= 5'(!latch_strobe_i);
            addr_cnt_o <= 5'(addr_phase_i);
            area_o <= area_sel_i;
         end
         else if (chip_sel_i)
         begin
            seen_r <= seen_r | latch_strobe_i;
            strobe_cnt_o <= strobe_cnt_o + 5'(latch_strobe_i);
            setup_cnt_o <= setup_cnt_o + 5'(!(seen_r | latch_strobe_i));
            addr_cnt_o <= addr_cnt_o + 5'(addr_phase_i);
         end
      end
   end
endmodule // mem_partner_model

// ===== dv/testbench.sv
// self-checking bench for the external bus latch timing block
`timescale 1ns/100ps
module testbench;
   import ext_bus_latch_pkg::*;
   // ============
   // stimulus and observed signals
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic acc_req_i = 1'b0;
   logic [27:0] acc_addr_i = 28'h0;
   logic acc_dma_i = 1'b0;
   logic [31:0] rdata, rdata_min; // read data, full and minimal
   logic busy, done, cs, strobe, aphase, ext_clk, irq;
   logic [1:0] resp;
   logic [AREA_IDX_W-1:0] area_sel, area_q;
   logic [4:0] st_cnt, s_cnt, a_cnt; // partner measurements
   logic [11:0] tv [4] = '{12'h45f, 12'h000, 12'hfff, 12'hf03}; // timings
   int mismatches = 0;
   int comparisons = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   // ============
   // design, minimal variant and memory model
   ext_bus_latch uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .acc_req_i(acc_req_i),
      .acc_addr_i(acc_addr_i), .acc_dma_i(acc_dma_i), .acc_busy_o(busy),
      .acc_done_o(done), .acc_resp_o(resp), .area_sel_o(area_sel),
      .chip_sel_o(cs), .address_latch_strobe_o(strobe),
      .addr_on_data_o(aphase), .ext_clk_o(ext_clk), .irq_o(irq));
   ext_bus_latch #(.MINIMAL_VARIANT(1'b1)) uut_min (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_min),
      .acc_req_i(acc_req_i), .acc_addr_i(acc_addr_i), .acc_dma_i(acc_dma_i),
      .acc_busy_o(), .acc_done_o(), .acc_resp_o(), .area_sel_o(),
      .chip_sel_o(), .address_latch_strobe_o(), .addr_on_data_o(),
      .ext_clk_o(), .irq_o());
   mem_partner_model mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .chip_sel_i(cs), .latch_strobe_i(strobe), .addr_phase_i(aphase),
      .area_sel_i(area_sel), .strobe_cnt_o(st_cnt), .setup_cnt_o(s_cnt),
      .addr_cnt_o(a_cnt), .area_o(area_q));
   // ============
   // tasks
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   // one-cycle read strobe, data checked in the following cycle
   task automatic rdc(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(what, rdata, exp);
   endtask
   task automatic start(input logic [27:0] a, input logic dma);
      @(posedge ref_clk_i);
      acc_addr_i <= a;
      acc_dma_i <= dma;
      acc_req_i <= 1'b1;
      @(posedge ref_clk_i);
      acc_req_i <= 1'b0;
   endtask
   // bounded wait for done; 3 marks a hang
   task automatic wait_done(output logic [1:0] r);
      r = 2'h3;
      for (int i = 0; i < 60; i++)
      begin
         @(posedge ref_clk_i);
         #1;
         if (done === 1'b1)
         begin
            r = resp;
            break;
         end
      end
      @(posedge ref_clk_i);
   endtask
   task automatic acc(input logic [27:0] a, output logic [1:0] r);
      start(a, 1'b0);
      wait_done(r);
   endtask
   // cycles between two clock rises, 0 when none
   task automatic clkper(output int p);
      int t0;
      logic pv;
      t0 = -1;
      p = 0;
      pv = ext_clk;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge ref_clk_i);
         #1;
         if (ext_clk === 1'b1 && pv === 1'b0)
         begin
            if (t0 >= 0 && p == 0)
               p = i - t0;
            t0 = i;
         end
         pv = ext_clk;
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ============
   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      mismatches++;
      stop_test();
   end
   // main sequence
   initial
   begin
      logic [1:0] r;
      int p;
      repeat (6) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < NUM_AREAS; i++)
         rdc("latch reset", 8'(LATCH_TIMING_BASE + 4 * i),
             32'(LATCH_TIMING_RST));
      rdc("divider reset", CLOCK_DIVIDER_OFS, 32'(CLOCK_DIVIDER_RST));
      rdc("unmapped reg", 8'hfc, 32'h0);
      clkper(p);
      chk("clock off", {ext_clk, 31'(p)}, 32'h80000000);
      wr(CLOCK_DIVIDER_OFS, 32'h03);
      clkper(p);
      chk("ratio ignored", {ext_clk, 31'(p)}, 32'h80000000);
      wr(CLOCK_DIVIDER_OFS, 32'h13);
      clkper(p);
      chk("divide 4", 32'(p), 32'h4);
      wr(CLOCK_DIVIDER_OFS, 32'h0f);
      wr(CLOCK_DIVIDER_OFS, 32'h1f);
      clkper(p);
      chk("divide 16", 32'(p), 32'h10);
      wr(CLOCK_DIVIDER_OFS, 32'h00);
      wr(CLOCK_DIVIDER_OFS, 32'h10);
      clkper(p);
      chk("undivided", {ext_clk, 31'(p)}, 32'h80000000);
      // unmapped access and interrupt
      acc({8'h80, 20'h0}, r);
      chk("unmapped resp", 32'(r), 32'(RESP_ERROR));
      chk("irq masked", 32'(irq), 32'h0);
      rdc("irq status", IRQ_STATUS_OFS, 32'h3);
      wr(IRQ_MASK_OFS, 32'h1);
      #1;
      chk("irq raised", 32'(irq), 32'h1);
      wr(IRQ_STATUS_OFS, 32'h1);
      #1;
      chk("irq cleared", 32'(irq), 32'h0);
      rdc("status left", IRQ_STATUS_OFS, 32'h2);
      // separate mode ignores latch timing
      acc(28'h0, r);
      chk("separate", {r, 20'h0, st_cnt, a_cnt}, 32'h0);
      // multiplexed mode timing table, no page read or ready wait
      wr(BUS_CTRL_OFS, 32'h1);
      foreach (tv[k])
      begin
         wr(LATCH_TIMING_BASE, 32'(tv[k]));
         acc(28'h0, r);
         chk("strobe width", 32'(st_cnt), 32'(tv[k][11:8]) + 1);
         chk("strobe setup", 32'(s_cnt), 32'(tv[k][7:4]));
         chk("addr hold", 32'(a_cnt), 32'(tv[k][3:0]) + 1);
      end
      // masked area compare
      wr(8'(AREA_BASE_OFS + 4), 32'h8003_0010);
      acc({8'h13, 20'h0}, r);
      chk("area hit", 32'({r, area_q}), 32'({RESP_OKAY, 3'h1}));
      acc({8'h14, 20'h0}, r);
      chk("masked miss", 32'(r), 32'(RESP_ERROR));
      // rewrite during a dma access waits for its end
      start(28'h0, 1'b1);
      wr(LATCH_TIMING_BASE, 32'h123);
      rdc("deferred", LATCH_TIMING_BASE, 32'hf03);
      wait_done(r);
      rdc("applied", LATCH_TIMING_BASE, 32'h123);
      // minimal variant has neither register
      chk("minimal latch", rdata_min, 32'h0);
      rdc("divider now", CLOCK_DIVIDER_OFS, 32'h10);
      chk("minimal divider", rdata_min, 32'h0);
      stop_test();
   end
endmodule // testbench
